// *** design/mct_pkg.sv ***
// Constants, register map and carrier types for the match/capture timer.
// Assumes a single 125 MHz clock and a plain strobe register port.
package mct_pkg;

  // Data width of the wide variant; narrow variant uses 16
  localparam int MCT_WIDE_W   = 32;
  localparam int MCT_NARROW_W = 16;
  localparam int MCT_NUM_MATCH = 4;
  localparam int MCT_NUM_PIN   = 2;

  // Register word offsets (byte addresses)
  localparam logic [7:0] MCT_CTRL_OFS    = 8'h00;
  localparam logic [7:0] MCT_COUNT_OFS   = 8'h04;
  localparam logic [7:0] MCT_PRELOAD_OFS = 8'h08;
  localparam logic [7:0] MCT_PRECNT_OFS  = 8'h0c;
  localparam logic [7:0] MCT_MCTL_OFS    = 8'h10;
  localparam logic [7:0] MCT_EXTCTL_OFS  = 8'h14;
  localparam logic [7:0] MCT_CAPCTL_OFS  = 8'h18;
  localparam logic [7:0] MCT_CAPVAL_OFS  = 8'h1c;
  localparam logic [7:0] MCT_STAT_OFS    = 8'h20;
  localparam logic [7:0] MCT_MASK_OFS    = 8'h24;
  localparam logic [7:0] MCT_PWM_OFS     = 8'h28;
  localparam logic [7:0] MCT_MATCH0_OFS  = 8'h30;

  // Control register fields
  localparam int MCT_CTRL_EN_BIT  = 0;
  localparam int MCT_CTRL_RST_BIT = 1;

  // Per-match control: three bits per match, interrupt/reset/stop
  localparam int MCT_MCTL_INT_BIT  = 0;
  localparam int MCT_MCTL_RST_BIT  = 1;
  localparam int MCT_MCTL_STOP_BIT = 2;
  localparam int MCT_MCTL_STRIDE   = 3;

  // Capture control fields
  localparam int MCT_CAP_RISE_BIT = 0;
  localparam int MCT_CAP_FALL_BIT = 1;

  // Status bit of the capture event (match flags are bits 3:0)
  localparam int MCT_STAT_CAP_BIT = 4;
  localparam int MCT_STAT_W       = 5;

  // Reset values
  localparam logic [31:0] MCT_ZERO_RST = 32'h0000_0000;

  // External match output actions
  typedef enum logic [1:0] {
    MCT_ACT_NONE   = 2'b00,
    MCT_ACT_LOW    = 2'b01,
    MCT_ACT_HIGH   = 2'b10,
    MCT_ACT_TOGGLE = 2'b11
  } mct_act_type;

  // Register access request carrier
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } mct_req_type;

endpackage

// *** design/mct_match_unit.sv ***
// One match comparator; the pin action logic sits in mct_timer.
// Assumes the counter and the run enable (en_reg and not hold_reg) come from the timer core.
`timescale 1ns/1ps
module mct_match_unit
  import mct_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] count,
  input  wire logic [W-1:0] match_val,
  input  wire logic         enable,
  output logic              hit
);

  // Compare every clock while the timer runs
  // match every cycle
  always_comb begin
    hit = enable && (count == match_val);
  end

  // Unused clock and reset kept so instances line up with the core
  logic unused_ok;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      unused_ok <= 1'b0;
    end else begin
      unused_ok <= 1'b1;
    end
  end

endmodule

// *** design/mct_timer.sv ***
// Match/capture counter-timer with prescaler, four match registers,
// two pinned match outputs, single-edge PWM and one capture input.
// Assumes synchronous capture input and one 125 MHz clock.
//
// Summary of operation
// - Narrow variant: 16-bit counter and prescaler
// - Wide variant: 32-bit counter, prescaler, matches
// - Four match registers, continue with interrupt
// - Match may halt the counter
// - Match may zero the counter
// - Two pins set, clear, toggle or hold
// - Two matches give single-edge PWM outputs
// - Counter runs on the peripheral clock
// - Capture edge latches count, optional interrupt
// - Actions happen when count hits match
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
module mct_timer
  import mct_pkg::*;
#(
  parameter int W = MCT_WIDE_W
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic [31:0]      rdata,
  input  wire logic        cap_in,
  output logic [1:0]       match_out,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [W-1:0]  count_reg;          // Timer counter
  logic [W-1:0]  pre_reg;            // Prescaler counter
  logic [W-1:0]  preload_reg;        // Prescaler terminal value
  logic [W-1:0]  match_reg [4];      // Match values
  logic [11:0]   mctl_reg;           // Int/reset/stop per match
  logic [3:0]    extctl_reg;         // Action per pin
  logic [1:0]    capctl_reg;         // Capture edge select
  logic [1:0]    pwm_reg;            // PWM enable per pin
  logic [W-1:0]  cap_reg;            // Captured count
  logic [4:0]    stat_reg;           // Sticky events
  logic [4:0]    mask_reg;           // Interrupt mask
  logic          en_reg;             // Counter enable
  logic          hold_reg;           // Counter held in reset
  logic          cap_prev_reg;       // Last capture level
  logic [3:0]    hit;                // Per-match compare
  logic          tick;               // Prescaler wrap
  logic          wr_ctrl;            // Control write strobe
  logic [4:0]    evt;                // New events this cycle

  mct_req_type req;
  assign req = '{wr: wr_stb, rd: rd_stb, addr: addr, wdata: wdata};
  assign wr_ctrl = req.wr && (req.addr == MCT_CTRL_OFS);

  ////////////////////////////////////////////////////////////////////////
  // Comparators, one per match register
  genvar gi;
  generate
    for (gi = 0; gi < MCT_NUM_MATCH; gi++) begin : g_match
      mct_match_unit #(.W(W)) u_match (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .count     (count_reg),
        .match_val (match_reg[gi]),
        .enable    (en_reg && !hold_reg),
        .hit       (hit[gi])
      );
    end
  endgenerate

  assign tick = en_reg && !hold_reg && (pre_reg == preload_reg);

  ////////////////////////////////////////////////////////////////////////
  // Prescaler, counts the peripheral clock directly
  // runs on ref_clk
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= '0;
    end else if (hold_reg || (req.wr && req.addr == MCT_PRECNT_OFS)) begin
      pre_reg <= hold_reg ? '0 : req.wdata[W-1:0];
    end else if (tick) begin
      pre_reg <= '0;
    end else if (en_reg) begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main counter with reset-on-match priority over increment
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else if (hold_reg) begin
      count_reg <= '0;
    end else if (req.wr && req.addr == MCT_COUNT_OFS) begin
      count_reg <= req.wdata[W-1:0];
    end else if (tick && |(hit & {mctl_reg[10], mctl_reg[7],
                                   mctl_reg[4], mctl_reg[1]})) begin
      count_reg <= '0;
    end else if (tick) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control: enable, hold, stop on match
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      en_reg   <= 1'b0;
      hold_reg <= 1'b0;
    end else if (wr_ctrl) begin
      en_reg   <= req.wdata[MCT_CTRL_EN_BIT];
      hold_reg <= req.wdata[MCT_CTRL_RST_BIT];
    end else if (|(hit & {mctl_reg[11], mctl_reg[8],
                          mctl_reg[5], mctl_reg[2]})) begin
      en_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      preload_reg <= '0;
      mctl_reg    <= '0;
      extctl_reg  <= '0;
      capctl_reg  <= '0;
      pwm_reg     <= '0;
      mask_reg    <= '0;
      for (int i = 0; i < MCT_NUM_MATCH; i++) begin
        match_reg[i] <= '0;
      end
    end else if (req.wr) begin
      case (req.addr)
        MCT_PRELOAD_OFS: preload_reg <= req.wdata[W-1:0];
        MCT_MCTL_OFS:    mctl_reg    <= req.wdata[11:0];
        MCT_EXTCTL_OFS:  extctl_reg  <= req.wdata[3:0];
        MCT_CAPCTL_OFS:  capctl_reg  <= req.wdata[1:0];
        MCT_PWM_OFS:     pwm_reg     <= req.wdata[1:0];
        MCT_MASK_OFS:    mask_reg    <= req.wdata[4:0];
        MCT_MATCH0_OFS:          match_reg[0] <= req.wdata[W-1:0];
        MCT_MATCH0_OFS + 8'h04:  match_reg[1] <= req.wdata[W-1:0];
        MCT_MATCH0_OFS + 8'h08:  match_reg[2] <= req.wdata[W-1:0];
        MCT_MATCH0_OFS + 8'h0c:  match_reg[3] <= req.wdata[W-1:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture edge detect; input taken as synchronous
  // capture on edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cap_prev_reg <= 1'b0;
      cap_reg      <= '0;
    end else begin
      cap_prev_reg <= cap_in;
      if (evt[MCT_STAT_CAP_BIT]) begin
        cap_reg <= count_reg;
      end
    end
  end

  // Events: match flags only raised when interrupt bit set
  always_comb begin
    evt[0] = hit[0] && tick && mctl_reg[0];
    evt[1] = hit[1] && tick && mctl_reg[3];
    evt[2] = hit[2] && tick && mctl_reg[6];
    evt[3] = hit[3] && tick && mctl_reg[9];
    evt[4] = (capctl_reg[MCT_CAP_RISE_BIT] && cap_in && !cap_prev_reg) ||
             (capctl_reg[MCT_CAP_FALL_BIT] && !cap_in && cap_prev_reg);
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status, write one clears, set wins over clear
  // write-one clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~((req.wr && req.addr == MCT_STAT_OFS) ?
                  req.wdata[4:0] : 5'h00)) | evt;
    end
  end

  // Level interrupt from next status and next mask, so a mask write
  // never leaves the pin one cycle behind the status it reports
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((stat_reg & ~((req.wr && req.addr == MCT_STAT_OFS) ?
              req.wdata[4:0] : 5'h00)) | evt) &
              ((req.wr && req.addr == MCT_MASK_OFS) ?
               req.wdata[4:0] : mask_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Match pins: PWM high from its match, low at cycle restart (count
  // back at zero); else the selected pin action
  // pin actions, single-edge PWM
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      match_out <= 2'b00;
    end else begin
      for (int p = 0; p < MCT_NUM_PIN; p++) begin
        if (pwm_reg[p]) begin
          if (hit[p] && tick) begin
            match_out[p] <= 1'b1;
          end else if (tick && count_reg == '0) begin
            match_out[p] <= 1'b0;
          end
        end else if (hit[p] && tick) begin
          case (mct_act_type'(extctl_reg[2*p +: 2]))
            MCT_ACT_LOW:    match_out[p] <= 1'b0;
            MCT_ACT_HIGH:   match_out[p] <= 1'b1;
            MCT_ACT_TOGGLE: match_out[p] <= ~match_out[p];
            default:        match_out[p] <= match_out[p];
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= MCT_ZERO_RST;
    end else if (req.rd) begin
      case (req.addr)
        MCT_CTRL_OFS:    rdata <= {30'h0, hold_reg, en_reg};
        MCT_COUNT_OFS:   rdata <= 32'(count_reg);
        MCT_PRELOAD_OFS: rdata <= 32'(preload_reg);
        MCT_PRECNT_OFS:  rdata <= 32'(pre_reg);
        MCT_MCTL_OFS:    rdata <= {20'h0, mctl_reg};
        MCT_EXTCTL_OFS:  rdata <= {28'h0, extctl_reg};
        MCT_CAPCTL_OFS:  rdata <= {30'h0, capctl_reg};
        MCT_CAPVAL_OFS:  rdata <= 32'(cap_reg);
        MCT_STAT_OFS:    rdata <= {27'h0, stat_reg};
        MCT_MASK_OFS:    rdata <= {27'h0, mask_reg};
        MCT_PWM_OFS:     rdata <= {30'h0, pwm_reg};
        MCT_MATCH0_OFS:          rdata <= 32'(match_reg[0]);
        MCT_MATCH0_OFS + 8'h04:  rdata <= 32'(match_reg[1]);
        MCT_MATCH0_OFS + 8'h08:  rdata <= 32'(match_reg[2]);
        MCT_MATCH0_OFS + 8'h0c:  rdata <= 32'(match_reg[3]);
        default:         rdata <= MCT_ZERO_RST;
      endcase
    end else begin
      rdata <= MCT_ZERO_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // stop halts counter
  stop_halts_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (hit[0] && mctl_reg[2] && !wr_ctrl) |=> !en_reg)
    else $error("stop on match did not halt");
  reset_zero_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (tick && |(hit & {mctl_reg[10], mctl_reg[7],
                      mctl_reg[4], mctl_reg[1]}) &&
     !(req.wr && req.addr == MCT_COUNT_OFS)) |=> count_reg == '0)
    else $error("reset on match did not zero count");
  count_step_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (tick && hit == 4'h0 && !(req.wr && req.addr == MCT_COUNT_OFS))
    |=> count_reg == $past(count_reg) + 1'b1)
    else $error("counter did not step on prescaler wrap");
  idle_hold_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (!en_reg && !hold_reg && !(req.wr && req.addr == MCT_COUNT_OFS))
    |=> $stable(count_reg))
    else $error("counter moved while disabled");
  capture_val_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    evt[4] |=> cap_reg == $past(count_reg) && stat_reg[4])
    else $error("capture did not latch");
  flag_set_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (tick && hit[0] && mctl_reg[0]) |=> stat_reg[0])
    else $error("match flag not set");
  flag_clear_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (req.wr && req.addr == MCT_STAT_OFS && req.wdata[0] && !evt[0])
    |=> !stat_reg[0])
    else $error("write one did not clear flag");
  toggle_pin_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (tick && hit[0] && !pwm_reg[0] && extctl_reg[1:0] == 2'b11)
    |=> match_out[0] != $past(match_out[0]))
    else $error("toggle action failed");
  pwm_high_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (tick && hit[1] && pwm_reg[1]) |=> match_out[1])
    else $error("pwm edge missing");
  irq_level_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    irq == |(stat_reg & mask_reg))
    else $error("interrupt level wrong");
  c_capture: cover property (@(posedge ref_clk) evt[4]);
  c_stop: cover property (@(posedge ref_clk) hit[0] && mctl_reg[2]);
  c_pwm: cover property (@(posedge ref_clk) pwm_reg[0] && hit[0] && tick);

endmodule

// *** verification/mct_pin_partner.sv ***
// Far-side model: capture signal source and load on the match pins.
// Assumes the timer's clock; cap_in only moves just after a rising edge.
`timescale 1ns/1ps
module mct_pin_partner (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [1:0] match_out,
  output logic            cap_in
);
  logic [15:0] high_cnt;  // Cycles pin 0 was seen high
  logic [15:0] high_cnt1; // Cycles pin 1 was seen high

  // Quiet source at time zero
  initial cap_in = 1'b0;

  ////////////////////////////////////////////////////////////
  // Pin loads: integrate high time, so duty needs no edge timing
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      high_cnt  <= 16'h0000;
      high_cnt1 <= 16'h0000;
    end else begin
      if (match_out[0] === 1'b1) begin
        high_cnt <= high_cnt + 16'h0001;
      end
      if (match_out[1] === 1'b1) begin
        high_cnt1 <= high_cnt1 + 16'h0001;
      end
    end
  end

  // Source: one level change after the next edge, then held
  task automatic drive_cap(input logic lvl);
    @(posedge ref_clk);
    cap_in <= lvl;
  endtask
endmodule

// *** verification/mct_timer_tb_top.sv ***
// Self-checking bench for the match/capture timer, wide variant.
// Assumes the package map and the strobe register port timing.
`timescale 1ns/1ps
module mct_timer_tb_top;
  import mct_pkg::*;
  logic        ref_clk, resetn, wr_stb, rd_stb, cap_in, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rv, c0, m, pl;
  logic [1:0]  match_out, p0, p1, e;
  logic [15:0] h0, h1;
  int          failures, tests_run, i;
  logic [7:0]  ofs[6] = '{MCT_CTRL_OFS, MCT_COUNT_OFS, MCT_STAT_OFS,
                          MCT_CAPVAL_OFS, MCT_MCTL_OFS, 8'h2c};
  mct_act_type acts[5] = '{MCT_ACT_HIGH, MCT_ACT_NONE, MCT_ACT_TOGGLE,
                           MCT_ACT_LOW, MCT_ACT_NONE};

  mct_timer #(.W(MCT_WIDE_W)) mct_timer_i (.ref_clk(ref_clk),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .cap_in(cap_in),
    .match_out(match_out), .irq(irq));
  mct_pin_partner mct_pin_partner_i (.ref_clk(ref_clk), .resetn(resetn),
    .match_out(match_out), .cap_in(cap_in));

  // 125 MHz clock
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////
  // Comparison, verdict and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Leading edge wait keeps strobes from being set twice in one step
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Bounded wait; running out counts as a mismatch
  task automatic wait_irq(input logic lvl);
    for (int k = 0; k < 64; k++) begin
      if (irq === lvl) return;
      wait_cyc(1);
    end
    failures++;
    wrap_up();
  endtask
  // Expected pin level after a match with the given action
  function automatic logic [1:0] pin_exp(mct_act_type a, logic [1:0] p);
    case (a)
      MCT_ACT_LOW:    return 2'h0;
      MCT_ACT_HIGH:   return 2'h3;
      MCT_ACT_TOGGLE: return ~p;
      default:        return p;
    endcase
  endfunction
  // High cycles per PWM period of length m3+1 with edge match m0
  function automatic logic [31:0] pwm_high(logic [31:0] m0, logic [31:0] m3);
    return m3 + 32'h1 - m0;
  endfunction

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    failures = 0;
    tests_run = 0;
    resetn = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    void'($urandom(95));
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    // Unmapped write must leave no trace; then reset values
    reg_wr(8'h2c, $urandom());
    foreach (ofs[j]) begin
      reg_rd(ofs[j], rv);
      check(rv, 32'h0);
    end
    // Four full-width match registers hold random words
    for (i = 0; i < 4; i++) begin
      m = $urandom();
      reg_wr(MCT_MATCH0_OFS + 8'(4 * i), m);
      reg_rd(MCT_MATCH0_OFS + 8'(4 * i), rv);
      check(rv, m);
    end
    // Prescaler: reads (pl+1)*5 cycles apart see exactly five steps
    pl = $urandom_range(1, 6);
    reg_wr(MCT_PRELOAD_OFS, pl);
    reg_wr(MCT_CTRL_OFS, 32'h1);
    reg_rd(MCT_COUNT_OFS, c0);
    wait_cyc((pl + 1) * 5 - 2);
    reg_rd(MCT_COUNT_OFS, rv);
    check(rv - c0, 32'h5);
    reg_wr(MCT_CTRL_OFS, 32'h2);
    reg_rd(MCT_COUNT_OFS, rv);
    check(rv, 32'h0);
    // Reset on match 0 with its interrupt unmasked
    m = $urandom_range(2, 9);
    reg_wr(MCT_PRELOAD_OFS, 32'h0);
    reg_wr(MCT_MATCH0_OFS, m);
    reg_wr(MCT_MCTL_OFS, 32'h3);
    reg_wr(MCT_MASK_OFS, 32'h1);
    reg_wr(MCT_STAT_OFS, 32'h1f);
    reg_wr(MCT_CTRL_OFS, 32'h1);
    wait_irq(1'b1);
    reg_rd(MCT_STAT_OFS, rv);
    check(rv[0], 32'h1);
    reg_rd(MCT_COUNT_OFS, rv);
    check(rv <= m, 32'h1);
    reg_wr(MCT_CTRL_OFS, 32'h0);
    reg_wr(MCT_STAT_OFS, 32'h1);
    wait_cyc(3);
    check(irq, 32'h0);
    // Pin actions: match 1 (0) acts first, match 0 (3) zeroes and stops
    reg_wr(MCT_CTRL_OFS, 32'h2);
    reg_wr(MCT_MASK_OFS, 32'h0);
    reg_wr(MCT_MATCH0_OFS, 32'h3);
    reg_wr(MCT_MATCH0_OFS + 8'h04, 32'h0);
    reg_wr(MCT_MCTL_OFS, 32'h6);
    e = 2'b00;
    for (i = 0; i < 5; i++) begin
      reg_wr(MCT_CTRL_OFS, 32'h2);
      reg_wr(MCT_EXTCTL_OFS, 32'({acts[4 - i], acts[i]}));
      reg_wr(MCT_CTRL_OFS, 32'h1);
      wait_cyc(8);
      p0 = pin_exp(acts[i], e);
      p1 = pin_exp(acts[4 - i], e);
      e = {p1[1], p0[0]};
      check(match_out, e);
      reg_rd(MCT_CTRL_OFS, rv);
      check(rv, 32'h0);
      reg_rd(MCT_COUNT_OFS, rv);
      check(rv, 32'h0);
    end
    // PWM on both pins, edges c0 and pl, period m+1
    // cycle length on unpinned match 3
    m = $urandom_range(4, 15);
    c0 = $urandom_range(1, m - 1);
    pl = $urandom_range(1, m - 1);
    reg_wr(MCT_CTRL_OFS, 32'h2);
    reg_wr(MCT_MATCH0_OFS, c0);
    reg_wr(MCT_MATCH0_OFS + 8'h04, pl);
    reg_wr(MCT_MATCH0_OFS + 8'h0c, m);
    reg_wr(MCT_MCTL_OFS, 32'h400);
    reg_wr(MCT_EXTCTL_OFS, 32'h0);
    reg_wr(MCT_PWM_OFS, 32'h3);
    reg_wr(MCT_CTRL_OFS, 32'h1);
    wait_cyc(2);
    h0 = mct_pin_partner_i.high_cnt;
    h1 = mct_pin_partner_i.high_cnt1;
    wait_cyc(4 * (m + 1));
    check(16'(mct_pin_partner_i.high_cnt - h0),
          32'h4 * pwm_high(c0, m));
    check(16'(mct_pin_partner_i.high_cnt1 - h1),
          32'h4 * pwm_high(pl, m));
    // Capture on rising, then falling; a rising edge then is ignored
    c0 = $urandom();
    pl = $urandom();
    reg_wr(MCT_CTRL_OFS, 32'h0);
    reg_wr(MCT_COUNT_OFS, c0);
    reg_wr(MCT_STAT_OFS, 32'h1f);
    reg_wr(MCT_MASK_OFS, 32'h10);
    reg_wr(MCT_CAPCTL_OFS, 32'h1);
    mct_pin_partner_i.drive_cap(1'b1);
    reg_rd(MCT_CAPVAL_OFS, rv);
    check(rv, c0);
    reg_rd(MCT_STAT_OFS, rv);
    check(rv, 32'h10);
    check(irq, 32'h1);
    reg_wr(MCT_CAPCTL_OFS, 32'h2);
    reg_wr(MCT_COUNT_OFS, pl);
    reg_wr(MCT_STAT_OFS, 32'h10);
    wait_cyc(1);
    check(irq, 32'h0);
    mct_pin_partner_i.drive_cap(1'b0);
    reg_rd(MCT_CAPVAL_OFS, rv);
    check(rv, pl);
    reg_wr(MCT_COUNT_OFS, c0);
    mct_pin_partner_i.drive_cap(1'b1);
    reg_rd(MCT_CAPVAL_OFS, rv);
    check(rv, pl);
    // Mid-run reset brings pins and capture back to zero
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    wait_cyc(1);
    check(match_out, 32'h0);
    reg_rd(MCT_CAPVAL_OFS, rv);
    check(rv, 32'h0);
    wrap_up();
  end
endmodule
